/* stt_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module stt_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0] cnt_q;
    wire push = in_valid_in && in_ready_out;
    wire pop = out_valid_out && out_ready_in;

    // Full and empty come from the count, so a stalled reader really fills it
    assign in_ready_out = cnt_q != (PW + 1)'(DEPTH);
    assign out_valid_out = cnt_q != '0;
    assign out_data_out = mem_q[rd_q];

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : bump

    // Storage is written only, never reset
    always_ff @(posedge sys_clk_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end

    // Pointers and fill count
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= bump(wr_q);
            end
            if (pop) begin
                rd_q <= bump(rd_q);
            end
            cnt_q <= cnt_q + (PW + 1)'(push) - (PW + 1)'(pop);
        end
    end
endmodule : stt_fifo

/* stt_host.sv */
// Host controller end: issues split requests and collects answers
`timescale 1ns/100ps
module stt_host #(
    parameter int SS_DEPTH = stt_pkg::SS_DEPTH
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    stt_link_if.host link,
    input wire logic cmd_valid_in,
    input wire stt_pkg::stt_kind_t cmd_kind_in,
    input wire stt_pkg::stt_xfer_t cmd_xfer_in,
    input wire logic cmd_low_in,
    input wire logic cmd_dir_in_in,
    input wire logic [stt_pkg::ADDR_W-1:0] cmd_addr_in,
    input wire logic [stt_pkg::DATA_W-1:0] cmd_data_in,
    output logic cmd_ready_out,
    output logic done_out,
    output stt_pkg::stt_code_t done_code_out,
    output logic [stt_pkg::DATA_W-1:0] done_data_out
);
    import stt_pkg::*;

    localparam int CW = $clog2(SS_DEPTH + 1);
    localparam int TW = $clog2(RSP_TIMEOUT_CYC + 1);

    stt_hst_t st_q;
    logic ready_q;
    logic req_valid_q;
    stt_kind_t req_kind_q;
    stt_xfer_t req_xfer_q;
    logic req_low_q;
    logic req_in_q;
    logic [ADDR_W-1:0] req_addr_q;
    logic [DATA_W-1:0] req_data_q;
    logic done_q;
    stt_code_t code_q;
    logic [DATA_W-1:0] ddata_q;
    logic [CW-1:0] credit_q;
    logic [TW-1:0] timer_q;

    wire take = cmd_valid_in && ready_q;
    wire cmd_per = is_periodic(cmd_xfer_in);
    // refuse a periodic start that would overrun the translator
    wire over = (cmd_kind_in == KIND_START) && cmd_per && (credit_q == CW'(SS_DEPTH));
    // no handshake is awaited for isochronous starts
    wire no_hs = (cmd_kind_in == KIND_START) && (cmd_xfer_in == XFER_ISO);
    wire got = (st_q == H_WAIT) && link.rsp_valid;
    wire expired = (st_q == H_WAIT) && (timer_q == '0);
    wire per_start = take && !over && (cmd_kind_in == KIND_START) && cmd_per;
    // a periodic result collected frees one slot of credit
    wire per_drain = got && (req_kind_q == KIND_COMPLETE) && is_periodic(req_xfer_q) &&
        (link.rsp_code != CODE_NYET);

    // Request issue and answer collection
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= H_IDLE;
            ready_q <= 1'b0;
            req_valid_q <= 1'b0;
            req_kind_q <= KIND_START;
            req_xfer_q <= XFER_CTRL;
            req_low_q <= 1'b0;
            req_in_q <= 1'b0;
            req_addr_q <= '0;
            req_data_q <= '0;
            done_q <= 1'b0;
            code_q <= CODE_NONE;
            ddata_q <= '0;
            timer_q <= '0;
        end else begin
            req_valid_q <= 1'b0;
            done_q <= 1'b0;
            case (st_q)
                H_IDLE: begin
                    ready_q <= !take;
                    if (take && over) begin
                        done_q <= 1'b1;
                        code_q <= CODE_ERR;
                    end else if (take) begin
                        // splits go to whatever address the command carries
                        req_valid_q <= 1'b1;
                        req_kind_q <= cmd_kind_in;
                        req_xfer_q <= cmd_xfer_in;
                        // low speed travels as a token bit
                        req_low_q <= cmd_low_in;
                        req_in_q <= cmd_dir_in_in;
                        req_addr_q <= cmd_addr_in;
                        req_data_q <= cmd_data_in;
                        timer_q <= TW'(RSP_TIMEOUT_CYC);
                        done_q <= no_hs;
                        code_q <= CODE_NONE;
                        st_q <= no_hs ? H_IDLE : H_WAIT;
                    end
                end
                H_WAIT: begin
                    timer_q <= timer_q - TW'(1);
                    if (got || expired) begin
                        done_q <= 1'b1;
                        code_q <= got ? link.rsp_code : CODE_ERR;
                        ddata_q <= link.rsp_data;
                        ready_q <= 1'b1;
                        st_q <= H_IDLE;
                    end
                end
                default: begin
                    st_q <= H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            credit_q <= '0;
        end else begin
            credit_q <= credit_q + CW'(per_start) - CW'(per_drain && credit_q != '0);
        end
    end

    assign link.req_valid = req_valid_q;
    assign link.req_kind = req_kind_q;
    assign link.req_xfer = req_xfer_q;
    assign link.req_low = req_low_q;
    assign link.req_dir_in = req_in_q;
    assign link.req_addr = req_addr_q;
    assign link.req_data = req_data_q;
    assign cmd_ready_out = ready_q;
    assign done_out = done_q;
    assign done_code_out = code_q;
    assign done_data_out = ddata_q;
endmodule : stt_host

/* stt_link_chk.sv */
// Protocol checker for the split link between host end and translator end
`timescale 1ns/100ps
module stt_link_chk #(
    parameter logic [stt_pkg::ADDR_W-1:0] OWN_ADDR = 7'h01
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic req_valid,
    input wire stt_pkg::stt_kind_t req_kind,
    input wire stt_pkg::stt_xfer_t req_xfer,
    input wire logic [stt_pkg::ADDR_W-1:0] req_addr,
    input wire logic rsp_valid,
    input wire stt_pkg::stt_code_t rsp_code
);
    import stt_pkg::*;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    // Request steps aimed at this translator
    sequence s_own;
        req_valid && req_addr == OWN_ADDR;
    endsequence
    sequence s_start;
        s_own ##0 req_kind == KIND_START;
    endsequence
    // Answers follow requests one cycle later, at most once per request
    chk_start_answer: assert property (s_start ##0 req_xfer != XFER_ISO |=> rsp_valid)
        else $error("start-split not answered");
    chk_iso_silent: assert property (s_start ##0 req_xfer == XFER_ISO |=> !rsp_valid)
        else $error("isochronous start-split answered");
    chk_int_acked: assert property (s_start ##0 req_xfer == XFER_INT |=> rsp_code == CODE_ACK)
        else $error("interrupt start-split not acknowledged");
    chk_cpl_answer: assert property (s_own ##0 req_kind == KIND_COMPLETE
        |=> rsp_valid && rsp_code != CODE_NONE)
        else $error("complete-split not answered");
    chk_foreign_quiet: assert property (req_valid && req_addr != OWN_ADDR |=> !rsp_valid)
        else $error("answer to a foreign address");
    chk_rsp_cause: assert property (rsp_valid |-> $past(req_valid))
        else $error("answer without request");
    chk_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
        else $error("answer longer than one cycle");
    chk_req_spacing: assert property (req_valid |=> !req_valid)
        else $error("requests back to back from host");
endmodule : stt_link_chk

/* stt_link_if.sv */
// Split transaction link between host controller and translator
`timescale 1ns/100ps
interface stt_link_if;
    import stt_pkg::*;

    logic req_valid;
    stt_kind_t req_kind;
    stt_xfer_t req_xfer;
    logic req_low;
    logic req_dir_in;
    logic [ADDR_W-1:0] req_addr;
    logic [DATA_W-1:0] req_data;
    logic rsp_valid;
    stt_code_t rsp_code;
    logic [DATA_W-1:0] rsp_data;

    modport host (
        output req_valid, req_kind, req_xfer, req_low, req_dir_in, req_addr, req_data,
        input rsp_valid, rsp_code, rsp_data
    );

    modport dev (
        input req_valid, req_kind, req_xfer, req_low, req_dir_in, req_addr, req_data,
        output rsp_valid, rsp_code, rsp_data
    );
endinterface : stt_link_if

/* stt_pkg.sv */
// Shared types and constants for the split transaction translator and its host end
package stt_pkg;

    // Link field widths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;

    // Default buffer depths
    localparam int SS_DEPTH = 8;
    localparam int CS_DEPTH = 8;
    localparam int NP_SLOTS = 2;

    // Microframe to frame timing
    localparam int UF_TIME_US = 125;
    localparam int FRAME_TIME_US = 1000;
    localparam int UF_PER_FRAME = FRAME_TIME_US / UF_TIME_US;
    localparam logic [2:0] UF_IDX_RST = 3'h0;
    localparam logic [2:0] UF_LAST = 3'(UF_PER_FRAME - 1);
    // Last microframe in which a bulk/control transfer may still start
    localparam logic [2:0] NP_LAST_UF = 3'h6;

    // Host answer timeout, rounded down to whole cycles
    localparam int CLK_PERIOD_NS = 5;
    localparam int RSP_TIMEOUT_NS = 80;
    localparam int RSP_TIMEOUT_CYC = RSP_TIMEOUT_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        XFER_CTRL = 2'h0,
        XFER_ISO = 2'h1,
        XFER_BULK = 2'h2,
        XFER_INT = 2'h3
    } stt_xfer_t;

    typedef enum logic {
        KIND_START = 1'h0,
        KIND_COMPLETE = 1'h1
    } stt_kind_t;

    typedef enum logic [2:0] {
        CODE_NONE = 3'h0,
        CODE_ACK = 3'h1,
        CODE_NAK = 3'h2,
        CODE_STALL = 3'h3,
        CODE_DATA = 3'h4,
        CODE_ERR = 3'h5,
        CODE_NYET = 3'h6
    } stt_code_t;

    typedef enum logic [3:0] {
        SLOT_FREE = 4'h1,
        SLOT_PEND = 4'h2,
        SLOT_BUSY = 4'h4,
        SLOT_READY = 4'h8
    } stt_slot_t;

    typedef enum logic [2:0] {
        DS_IDLE = 3'h1,
        DS_BUSY = 3'h2,
        DS_PUSH = 3'h4
    } stt_ds_t;

    typedef enum logic [1:0] {
        H_IDLE = 2'h1,
        H_WAIT = 2'h2
    } stt_hst_t;

    // Buffered start-split and complete-split entries
    typedef struct packed {
        stt_xfer_t xfer;
        logic low;
        logic dir_in;
        logic [DATA_W-1:0] data;
    } stt_ss_t;

    typedef struct packed {
        stt_xfer_t xfer;
        stt_code_t code;
        logic [DATA_W-1:0] data;
    } stt_cs_t;

    function automatic logic is_periodic(input stt_xfer_t xfer);
        return (xfer == XFER_ISO) || (xfer == XFER_INT);
    endfunction : is_periodic

endpackage : stt_pkg

/* stt_translator.sv */
// Translator end: high-speed split handler, buffers and downstream handler
`timescale 1ns/100ps
module stt_translator #(
    parameter logic [stt_pkg::ADDR_W-1:0] OWN_ADDR = 7'h01,
    parameter logic PER_PORT_XLAT = 1'b0,
    parameter int SS_DEPTH = stt_pkg::SS_DEPTH,
    parameter int CS_DEPTH = stt_pkg::CS_DEPTH,
    parameter int NP_SLOTS = stt_pkg::NP_SLOTS
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    stt_link_if.dev link,
    input wire logic uframe_tick_in,
    input wire logic ds_done_in,
    input wire stt_pkg::stt_code_t ds_code_in,
    input wire logic [stt_pkg::DATA_W-1:0] ds_rdata_in,
    output logic ds_start_out,
    output stt_pkg::stt_xfer_t ds_xfer_out,
    output logic ds_low_out,
    output logic ds_dir_in_out,
    output logic [stt_pkg::DATA_W-1:0] ds_data_out,
    output logic sof_out,
    output logic multi_xlat_out
);
    import stt_pkg::*;

    localparam int IW = (NP_SLOTS > 1) ? $clog2(NP_SLOTS) : 1;

    // Link answer registers
    logic rsp_valid_q;
    stt_code_t rsp_code_q;
    logic [DATA_W-1:0] rsp_data_q;

    // Non-periodic slots
    stt_slot_t np_st_q [NP_SLOTS];
    stt_xfer_t np_xfer_q [NP_SLOTS];
    logic np_low_q [NP_SLOTS];
    logic np_in_q [NP_SLOTS];
    logic [DATA_W-1:0] np_data_q [NP_SLOTS];
    stt_code_t np_code_q [NP_SLOTS];
    logic [IW-1:0] rr_q;

    // Downstream handler state
    stt_ds_t ds_st_q;
    logic cur_per_q;
    logic [IW-1:0] cur_slot_q;
    stt_cs_t res_q;
    logic ds_start_q;
    stt_xfer_t ds_xfer_q;
    logic ds_low_q;
    logic ds_in_q;
    logic [DATA_W-1:0] ds_data_q;

    // Frame timing and flags
    logic [2:0] uf_idx_q;
    logic sof_q;
    logic ovf_q;
    logic multi_q;

    // Periodic FIFO ports
    logic ss_in_ready;
    logic ss_out_valid;
    stt_ss_t ss_head;
    logic cs_in_ready;
    logic cs_out_valid;
    stt_cs_t cs_head;
    stt_ss_t ss_entry;

    function automatic logic [IW-1:0] first_set(input logic [NP_SLOTS-1:0] mask);
        logic [IW-1:0] idx;
        idx = '0;
        for (int i = NP_SLOTS - 1; i >= 0; i--) begin
            if (mask[i]) begin
                idx = IW'(i);
            end
        end
        return idx;
    endfunction : first_set

    wire req_me = link.req_valid && (link.req_addr == OWN_ADDR);
    wire req_ss = req_me && (link.req_kind == KIND_START);
    wire req_cs = req_me && (link.req_kind == KIND_COMPLETE);
    wire req_per = is_periodic(link.req_xfer);

    // Slot masks for allocate, launch and retire
    logic [NP_SLOTS-1:0] free_m, pend_m, pend_hi_m, ready_m, used_m;
    for (genvar g = 0; g < NP_SLOTS; g++) begin : g_mask
        assign free_m[g] = np_st_q[g] == SLOT_FREE;
        assign pend_m[g] = np_st_q[g] == SLOT_PEND;
        assign pend_hi_m[g] = pend_m[g] && (IW'(g) >= rr_q);
        assign ready_m[g] = (np_st_q[g] == SLOT_READY) && (np_xfer_q[g] == link.req_xfer);
        assign used_m[g] = !free_m[g] && (np_xfer_q[g] == link.req_xfer);
    end

    wire [IW-1:0] free_idx = first_set(free_m);
    wire [IW-1:0] ready_idx = first_set(ready_m);
    // Round robin among pending bulk/control slots
    wire [IW-1:0] pick_idx = (|pend_hi_m) ? first_set(pend_hi_m) : first_set(pend_m);
    wire ds_idle = ds_st_q == DS_IDLE;
    wire np_window = uf_idx_q <= NP_LAST_UF;
    wire uf_last = uf_idx_q == UF_LAST;

    // full periodic buffer drops the start-split
    wire ovf_set = req_ss && req_per && !ss_in_ready;
    wire ovf_clr = req_cs && req_per;
    wire np_alloc = req_ss && !req_per && (|free_m);
    wire np_retire = req_cs && !req_per && (|ready_m);
    // periodic head consumed first, in order
    wire ss_pop = ds_idle && ss_out_valid;
    // bulk/control only with no periodic work and time left
    wire np_launch = ds_idle && !ss_out_valid && (|pend_m) && np_window;
    wire np_land = (ds_st_q == DS_BUSY) && ds_done_in && !cur_per_q;
    wire cs_match = cs_head.xfer == link.req_xfer;
    wire cs_pop = req_cs && req_per && !ovf_q && cs_out_valid && cs_match;

    // answer from the head of the relevant buffer
    wire stt_code_t per_cs_code = ovf_q ? CODE_ERR :
        !cs_out_valid ? CODE_NYET : cs_match ? cs_head.code : CODE_ERR;
    wire stt_code_t np_cs_code = (|ready_m) ? np_code_q[ready_idx] :
        (|used_m) ? CODE_NYET : CODE_ERR;
    // acknowledge accepted start-splits, NAK a full non-periodic section
    wire stt_code_t ss_code = (req_per || (|free_m)) ? CODE_ACK : CODE_NAK;
    wire rsp_send = req_ss ? (link.req_xfer != XFER_ISO) : req_cs;
    wire stt_code_t rsp_code_d = req_ss ? ss_code : req_per ? per_cs_code : np_cs_code;
    wire [DATA_W-1:0] rsp_data_d = req_per ? cs_head.data : np_data_q[ready_idx];

    assign ss_entry = '{xfer: link.req_xfer, low: link.req_low, dir_in: link.req_dir_in,
                        data: link.req_data};

    // start-split storage of the periodic pipeline
    stt_fifo #(.WIDTH($bits(stt_ss_t)), .DEPTH(SS_DEPTH)) u_ss_fifo (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .in_valid_in(req_ss && req_per),
        .in_ready_out(ss_in_ready),
        .in_data_in(ss_entry),
        .out_valid_out(ss_out_valid),
        .out_ready_in(ss_pop),
        .out_data_out(ss_head)
    );

    // complete-split results of the periodic pipeline
    stt_fifo #(.WIDTH($bits(stt_cs_t)), .DEPTH(CS_DEPTH)) u_cs_fifo (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .in_valid_in(ds_st_q == DS_PUSH),
        .in_ready_out(cs_in_ready),
        .in_data_in(res_q),
        .out_valid_out(cs_out_valid),
        .out_ready_in(cs_pop),
        .out_data_out(cs_head)
    );

    // Link answer, one cycle after the request
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rsp_valid_q <= 1'b0;
            rsp_code_q <= CODE_NONE;
            rsp_data_q <= '0;
        end else begin
            rsp_valid_q <= rsp_send;
            rsp_code_q <= rsp_code_d;
            rsp_data_q <= rsp_data_d;
        end
    end

    // Overflow flag; a new drop in the reporting cycle stays set
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ovf_q <= 1'b0;
        end else begin
            // record loss for the next complete-split
            ovf_q <= ovf_set || (ovf_q && !ovf_clr);
        end
    end

    // Non-periodic slots; each event touches a slot in a distinct state
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < NP_SLOTS; i++) begin
                np_st_q[i] <= SLOT_FREE;
                np_xfer_q[i] <= XFER_CTRL;
                np_low_q[i] <= 1'b0;
                np_in_q[i] <= 1'b0;
                np_data_q[i] <= '0;
                np_code_q[i] <= CODE_NONE;
            end
            rr_q <= '0;
        end else begin
            // slot state walks free, pending, busy, ready
            if (np_alloc) begin
                np_st_q[free_idx] <= SLOT_PEND;
                np_xfer_q[free_idx] <= link.req_xfer;
                np_low_q[free_idx] <= link.req_low;
                np_in_q[free_idx] <= link.req_dir_in;
                np_data_q[free_idx] <= link.req_data;
            end
            if (np_launch) begin
                np_st_q[pick_idx] <= SLOT_BUSY;
                rr_q <= pick_idx + IW'(1);
            end
            if (np_land) begin
                np_st_q[cur_slot_q] <= SLOT_READY;
                np_code_q[cur_slot_q] <= ds_code_in;
                np_data_q[cur_slot_q] <= ds_rdata_in;
            end
            if (np_retire) begin
                np_st_q[ready_idx] <= SLOT_FREE;
            end
        end
    end

    // downstream handler sees only the buffers
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ds_st_q <= DS_IDLE;
            cur_per_q <= 1'b0;
            cur_slot_q <= '0;
            res_q <= '0;
            ds_start_q <= 1'b0;
            ds_xfer_q <= XFER_CTRL;
            ds_low_q <= 1'b0;
            ds_in_q <= 1'b0;
            ds_data_q <= '0;
        end else begin
            ds_start_q <= 1'b0;
            case (ds_st_q)
                DS_IDLE: begin
                    if (ss_pop) begin
                        ds_start_q <= 1'b1;
                        ds_xfer_q <= ss_head.xfer;
                        // low-speed marking is applied only downstream
                        ds_low_q <= ss_head.low;
                        ds_in_q <= ss_head.dir_in;
                        ds_data_q <= ss_head.data;
                        cur_per_q <= 1'b1;
                        ds_st_q <= DS_BUSY;
                    end else if (np_launch) begin
                        ds_start_q <= 1'b1;
                        ds_xfer_q <= np_xfer_q[pick_idx];
                        ds_low_q <= np_low_q[pick_idx];
                        ds_in_q <= np_in_q[pick_idx];
                        ds_data_q <= np_data_q[pick_idx];
                        cur_per_q <= 1'b0;
                        cur_slot_q <= pick_idx;
                        ds_st_q <= DS_BUSY;
                    end
                end
                DS_BUSY: begin
                    if (ds_done_in) begin
                        // periodic result heads for the complete buffer
                        res_q <= '{xfer: ds_xfer_q, code: ds_code_in, data: ds_rdata_in};
                        ds_st_q <= cur_per_q ? DS_PUSH : DS_IDLE;
                    end
                end
                DS_PUSH: begin
                    // A full result buffer stalls the downstream handler
                    if (cs_in_ready) begin
                        ds_st_q <= DS_IDLE;
                    end
                end
                default: begin
                    ds_st_q <= DS_IDLE;
                end
            endcase
        end
    end

    // Microframe count and derived frame start
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            uf_idx_q <= UF_IDX_RST;
            sof_q <= 1'b0;
            multi_q <= 1'b0;
        end else begin
            // every eighth microframe tick starts a frame
            sof_q <= uframe_tick_in && uf_last;
            if (uframe_tick_in) begin
                uf_idx_q <= uf_last ? UF_IDX_RST : uf_idx_q + 3'h1;
            end
            multi_q <= PER_PORT_XLAT;
        end
    end

    assign link.rsp_valid = rsp_valid_q;
    assign link.rsp_code = rsp_code_q;
    assign link.rsp_data = rsp_data_q;
    assign ds_start_out = ds_start_q;
    assign ds_xfer_out = ds_xfer_q;
    assign ds_low_out = ds_low_q;
    assign ds_dir_in_out = ds_in_q;
    assign ds_data_out = ds_data_q;
    assign sof_out = sof_q;
    assign multi_xlat_out = multi_q;
endmodule : stt_translator

/* tb_stt.sv */
// Testbench joining host end and translator end over the split link
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] %0t mismatch at line %0d", $time, `__LINE__); end end
module tb;
    import stt_pkg::*;
    logic sys_clk_in, rst_in, cmd_valid, cmd_ready, done, uf_tick, ds_done, ds_start, ds_low;
    logic ds_dir, sof, multi_xlat, cmd_low, cmd_dir;
    logic [6:0] cmd_addr;
    logic [7:0] cmd_data, done_data, ds_rdata, ds_data;
    stt_kind_t cmd_kind;
    stt_xfer_t cmd_xfer, ds_xfer;
    stt_code_t done_code, ds_code;
    logic [11:0] ds_q[$];
    int miscompares, comparisons, sof_seen;
    stt_link_if link ();
    stt_translator #(.PER_PORT_XLAT(1'b1)) u_stt_translator (.sys_clk_in(sys_clk_in),
        .rst_in(rst_in), .link(link), .uframe_tick_in(uf_tick), .ds_done_in(ds_done),
        .ds_code_in(ds_code), .ds_rdata_in(ds_rdata), .ds_start_out(ds_start),
        .ds_xfer_out(ds_xfer), .ds_low_out(ds_low), .ds_dir_in_out(ds_dir),
        .ds_data_out(ds_data), .sof_out(sof), .multi_xlat_out(multi_xlat));
    stt_host u_stt_host (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .link(link),
        .cmd_valid_in(cmd_valid), .cmd_kind_in(cmd_kind), .cmd_xfer_in(cmd_xfer),
        .cmd_low_in(cmd_low), .cmd_dir_in_in(cmd_dir), .cmd_addr_in(cmd_addr),
        .cmd_data_in(cmd_data), .cmd_ready_out(cmd_ready), .done_out(done),
        .done_code_out(done_code), .done_data_out(done_data));
    stt_link_chk #(.OWN_ADDR(7'h01)) u_stt_link_chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .req_valid(link.req_valid), .req_kind(link.req_kind), .req_xfer(link.req_xfer),
        .req_addr(link.req_addr), .rsp_valid(link.rsp_valid), .rsp_code(link.rsp_code));
    // 200 MHz clock
    initial begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    // Record downstream starts so none is missed while a command runs
    always @(posedge sys_clk_in) begin
        if (ds_start === 1'b1) ds_q.push_back({ds_xfer, ds_low, ds_dir, ds_data});
        if (sof === 1'b1) sof_seen++;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask : tick
    task automatic stop_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    // One host command; the isochronous start has no handshake to judge
    task automatic send(input stt_kind_t k, input stt_xfer_t x, input logic [7:0] v,
                        input stt_code_t ec, input logic [6:0] a = 7'h01);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 50) begin tick(1); n++; end
        cmd_kind = k;
        cmd_xfer = x;
        cmd_data = v;
        cmd_addr = a;
        cmd_valid = 1'b1;
        tick(1);
        cmd_valid = 1'b0;
        while (done !== 1'b1 && n < 50) begin tick(1); n++; end
        if (n >= 50) begin miscompares++; stop_test(); end
        if (k != KIND_START || x != XFER_ISO) `CHK(done_code, ec)
    endtask : send
    // Next downstream start must carry the oldest buffered request
    task automatic expect_ds(input stt_xfer_t x, input logic [7:0] v, input logic [1:0] ld = 2'h0);
        int n;
        n = 0;
        while (ds_q.size() == 0 && n < 50) begin tick(1); n++; end
        if (n >= 50) begin miscompares++; stop_test(); end
        `CHK(ds_q.pop_front(), {x, ld, v})
    endtask : expect_ds
    task automatic ds_end(input stt_code_t c, input logic [7:0] d);
        ds_code = c;
        ds_rdata = d;
        ds_done = 1'b1;
        tick(1);
        ds_done = 1'b0;
        tick(2);
    endtask : ds_end
    task automatic test_frame();
        repeat (8) begin uf_tick = 1'b1; tick(1); uf_tick = 1'b0; tick(3); end
        `CHK(sof_seen, 1)
        `CHK(multi_xlat, 1'b1)
        $display("test_frame finished");
    endtask : test_frame
    // Bulk result is held until retrieved, then the slot is gone
    task automatic test_bulk();
        send(KIND_START, XFER_BULK, 8'h5a, CODE_ACK);
        expect_ds(XFER_BULK, 8'h5a);
        send(KIND_COMPLETE, XFER_BULK, 8'h00, CODE_NYET);
        ds_end(CODE_STALL, 8'h00);
        send(KIND_COMPLETE, XFER_BULK, 8'h00, CODE_STALL);
        send(KIND_COMPLETE, XFER_BULK, 8'h00, CODE_ERR);
        send(KIND_START, XFER_CTRL, 8'h00, CODE_ERR, 7'h02);
        $display("test_bulk finished");
    endtask : test_bulk
    // Two periodic starts pass the pipeline in arrival order
    task automatic test_periodic();
        // Low-speed IN targets, so the token flag must reach the downstream side
        {cmd_low, cmd_dir} = 2'h3;
        send(KIND_START, XFER_ISO, 8'h11, CODE_NONE);
        send(KIND_START, XFER_INT, 8'h22, CODE_ACK);
        expect_ds(XFER_ISO, 8'h11, 2'h3);
        send(KIND_COMPLETE, XFER_ISO, 8'h00, CODE_NYET);
        ds_end(CODE_ACK, 8'h00);
        expect_ds(XFER_INT, 8'h22, 2'h3);
        ds_end(CODE_DATA, 8'h44);
        send(KIND_COMPLETE, XFER_ISO, 8'h00, CODE_ACK);
        send(KIND_COMPLETE, XFER_INT, 8'h00, CODE_DATA);
        `CHK(done_data, 8'h44)
        $display("test_periodic finished");
    endtask : test_periodic
    // Host refuses a periodic start beyond the translator's start buffer
    task automatic test_credit();
        repeat (8) send(KIND_START, XFER_INT, 8'h33, CODE_ACK);
        send(KIND_START, XFER_INT, 8'h33, CODE_ERR);
        $display("test_credit finished");
    endtask : test_credit
    // Main sequence
    initial begin
        {rst_in, cmd_valid, cmd_low, cmd_dir, uf_tick, ds_done} = 6'h20;
        {cmd_addr, cmd_data, ds_rdata} = 23'h0;
        cmd_kind = KIND_START;
        cmd_xfer = XFER_CTRL;
        ds_code = CODE_NONE;
        repeat (12) @(posedge sys_clk_in);
        #1 rst_in = 1'b0;
        tick(2);
        test_frame();
        test_bulk();
        test_periodic();
        test_credit();
        stop_test();
    end
endmodule : tb
